// File: scg_pkg.sv
// Package for the serial clock generator: register map, fields, carriers.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package scg_pkg;
	localparam logic [7:0] SCG_ADDR_CLK_CTRL = 8'h14;
	localparam logic [7:0] SCG_ADDR_STATUS = 8'h18;
	localparam logic [7:0] SCG_ADDR_ENABLE = 8'h20;
	localparam int SCG_DIV_LSB = 16;
	localparam int SCG_DIV_W = 4;
	localparam int SCG_HI_LSB = 8;
	localparam int SCG_LO_LSB = 0;
	localparam int SCG_PHASE_W = 8;
	localparam logic [3:0] SCG_DIV_MAX = 4'h8;
	localparam logic [7:0] SCG_PHASE_ZERO = 8'h00;
	localparam logic [7:0] SCG_PHASE_ONE = 8'h01;
	localparam logic [31:0] SCG_CTRL_MASK = 32'h000FFFFF;
	localparam logic [31:0] SCG_CTRL_RESET = 32'h00000000;
	localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;
	localparam int SCG_CLK_HZ = 20000000;
	localparam int SCG_CLK_PERIOD_NS = 1000000000 / SCG_CLK_HZ;

	typedef struct packed {
		logic [3:0] clk_scale;
		logic [7:0] sck_upper_phase_len;
		logic [7:0] sck_bottom_phase_len;
	} scg_cfg_s;

	typedef enum logic [2:0] {
		SCG_IDLE = 3'h1,
		SCG_HIGH = 3'h2,
		SCG_LOW = 3'h4
	} scg_state_e;
endpackage

// File: scg_prescaler.sv
// Power-of-two prescaler giving a one-cycle enable per scaled period.
// Assumes the exponent is held stable while running.
`timescale 1ns/100ps
module scg_prescaler #(
	parameter int CNT_W = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [3:0] scale,
	output logic tick
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] limit;

	assign limit = CNT_W'((1 << scale) - 1);

	// Counter restarts whenever the generator is idle so the first
	// scaled period after start is a full one.
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count >= limit) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// File: scg_sck_target.sv
// Target-side model: times the high and low phases of the serial clock.
// Assumes sck is sampled on the system clock and is low during reset.
`timescale 1ns/100ps
module scg_sck_target (
	input wire logic aclk,
	input wire logic sck,
	output int hi_len,
	output int lo_len,
	output int n_edges
);
	logic last = 1'b0;
	int cnt = 0;
	// A target sees only levels, so phase lengths are counted in samples.
	// A line not yet driven before reset counts as low, so that reset
	// does not show up as a false pair of edges.
	always @(posedge aclk) begin
		if ((sck === 1'b1) != last) begin
			if (last)
				hi_len <= cnt;
			else
				lo_len <= cnt;
			n_edges <= n_edges + 1;
			cnt <= 1;
		end else
			cnt <= cnt + 1;
		last <= (sck === 1'b1);
	end
endmodule

// File: scg_top.sv
// Serial clock generator with an AXI4-Lite register slave.
// Assumes AXI4-Lite masters with one write and one read outstanding.
//
// Contract
// - Peripheral clock is input over two-to-scale; the 9-bit prescaler holds the divider at 512 for scales 10 to 15.
// - Nonzero high field sets high periods.
// - Zero high field disables high control.
// - Nonzero low field sets low periods.
// - High plus low fields set period.
`timescale 1ns/100ps
module scg_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sck
);
	logic [31:0] ctrl;
	logic enable;
	scg_pkg::scg_cfg_s cfg;
	scg_pkg::scg_state_e state;
	logic [7:0] phase_cnt;
	logic tick;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] wr_merged;
	logic [7:0] hi_len;
	logic [7:0] lo_len;

	assign cfg = ctrl[19:0];
	// zero disables control
	// A zero high field falls back to one scaled period, the shortest
	// legal phase, rather than stalling the clock.
	assign hi_len = (cfg.sck_upper_phase_len == scg_pkg::SCG_PHASE_ZERO) ?
		scg_pkg::SCG_PHASE_ONE : cfg.sck_upper_phase_len;
	assign lo_len = (cfg.sck_bottom_phase_len == scg_pkg::SCG_PHASE_ZERO) ?
		scg_pkg::SCG_PHASE_ONE : cfg.sck_bottom_phase_len;

	scg_prescaler #(
		.CNT_W(9)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(state != scg_pkg::SCG_IDLE),
		.scale(cfg.clk_scale),
		.tick(tick)
	);

	// Write channel: address and data may arrive in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (aw_held && w_held) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
		end
	end

	always_comb begin
		wr_merged = ctrl;
		for (int i = 0; i < 4; i++) begin
			if (w_strb[i]) begin
				wr_merged[i*8 +: 8] = w_data[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= scg_pkg::SCG_CTRL_RESET;
			enable <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= scg_pkg::SCG_RESP_OKAY;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= scg_pkg::SCG_RESP_OKAY;
			if (aw_addr == scg_pkg::SCG_ADDR_CLK_CTRL) begin
				ctrl <= wr_merged & scg_pkg::SCG_CTRL_MASK;
			end else if (aw_addr == scg_pkg::SCG_ADDR_ENABLE) begin
				if (w_strb[0]) begin
					enable <= w_data[0];
				end
			end else if (aw_addr != scg_pkg::SCG_ADDR_STATUS) begin
				s_axi_bresp <= scg_pkg::SCG_RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= scg_pkg::SCG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= scg_pkg::SCG_RESP_OKAY;
			case (s_axi_araddr)
				scg_pkg::SCG_ADDR_CLK_CTRL: s_axi_rdata <= ctrl;
				scg_pkg::SCG_ADDR_ENABLE: s_axi_rdata <= {31'h0, enable};
				scg_pkg::SCG_ADDR_STATUS: s_axi_rdata <= {29'h0, state};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= scg_pkg::SCG_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
		end
	end

	// alternating high and low
	// The counter loads the next phase's length at each serial clock edge,
	// so a field change takes effect from the next phase on.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= scg_pkg::SCG_IDLE;
			phase_cnt <= 8'h00;
			sck <= 1'b0;
		end else begin
			case (state)
				scg_pkg::SCG_IDLE: begin
					sck <= 1'b0;
					if (enable) begin
						state <= scg_pkg::SCG_HIGH;
						phase_cnt <= hi_len;
						sck <= 1'b1;
					end
				end
				scg_pkg::SCG_HIGH: begin
					if (tick) begin
						if (phase_cnt == scg_pkg::SCG_PHASE_ONE) begin
							state <= scg_pkg::SCG_LOW;
							phase_cnt <= lo_len;
							sck <= 1'b0;
						end else begin
							phase_cnt <= phase_cnt - 1'b1;
						end
					end
				end
				scg_pkg::SCG_LOW: begin
					if (tick) begin
						if (phase_cnt != scg_pkg::SCG_PHASE_ONE) begin
							phase_cnt <= phase_cnt - 1'b1;
						end else if (enable) begin
							state <= scg_pkg::SCG_HIGH;
							phase_cnt <= hi_len;
							sck <= 1'b1;
						end else begin
							state <= scg_pkg::SCG_IDLE;
						end
					end
				end
				default: begin
					state <= scg_pkg::SCG_IDLE;
					sck <= 1'b0;
				end
			endcase
		end
	end

	// Assertion helpers: the phase length as it was loaded and the scaled
	// periods seen since that load. Keeping the loaded length means a
	// field written in mid-phase does not upset the length checks.
	logic phase_load;
	logic [7:0] len_loaded;
	logic [7:0] ticks_in_phase;
	always_comb begin
		phase_load = 1'b0;
		if (state == scg_pkg::SCG_IDLE) begin
			phase_load = enable;
		end else if (tick && phase_cnt == scg_pkg::SCG_PHASE_ONE) begin
			phase_load = (state == scg_pkg::SCG_HIGH) || enable;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			len_loaded <= 8'h00;
			ticks_in_phase <= 8'h00;
		end else if (phase_load) begin
			len_loaded <= (state == scg_pkg::SCG_HIGH) ? lo_len : hi_len;
			ticks_in_phase <= 8'h00;
		end else if (tick) begin
			ticks_in_phase <= ticks_in_phase + 8'h01;
		end
	end

	high_len_ok_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$fell(sck) && $past(state) == scg_pkg::SCG_HIGH |->
		$past(ticks_in_phase) + 8'h01 == $past(len_loaded))
		else $error("high phase length wrong");
	low_len_ok_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(sck) && $past(state) == scg_pkg::SCG_LOW |->
		$past(ticks_in_phase) + 8'h01 == $past(len_loaded))
		else $error("low phase length wrong");
	zero_hi_one_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(sck) &&
		$past(cfg.sck_upper_phase_len) == scg_pkg::SCG_PHASE_ZERO |->
		phase_cnt == scg_pkg::SCG_PHASE_ONE)
		else $error("zero high field not one period");
	tick_spacing_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		tick && cfg.clk_scale == 4'h1 && state != scg_pkg::SCG_IDLE ##1
		cfg.clk_scale == 4'h1 && state != scg_pkg::SCG_IDLE |->
		!tick ##1 tick)
		else $error("prescale spacing wrong");
	tick_scale0_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		tick && cfg.clk_scale == 4'h0 && state != scg_pkg::SCG_IDLE &&
		!(state == scg_pkg::SCG_LOW && phase_cnt == scg_pkg::SCG_PHASE_ONE)
		|=> tick)
		else $error("unscaled tick missing");
	sck_state_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		sck == (state == scg_pkg::SCG_HIGH))
		else $error("sck disagrees with phase");
	reload_hi_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(sck) |-> phase_cnt == $past(hi_len))
		else $error("high reload wrong");
	reload_lo_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$fell(sck) |-> phase_cnt == $past(lo_len))
		else $error("low reload wrong");
	cnt_down_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		tick && state != scg_pkg::SCG_IDLE &&
		phase_cnt > scg_pkg::SCG_PHASE_ONE |=>
		phase_cnt == $past(phase_cnt) - 8'h01)
		else $error("phase counter not counting down");

	run_cov: cover property (@(posedge aclk) $rose(sck));
	long_hi_cov: cover property (@(posedge aclk)
		$fell(sck) && $past(hi_len) == 8'h0F);
	stop_cov: cover property (@(posedge aclk)
		$past(state) == scg_pkg::SCG_LOW && state == scg_pkg::SCG_IDLE);
	err_cov: cover property (@(posedge aclk)
		s_axi_bvalid && s_axi_bresp == scg_pkg::SCG_RESP_SLVERR);
endmodule

// File: tb.sv
// Self-checking bench for the serial clock generator.
// Assumes scg_top with its AXI4-Lite slave and the sck output.
`timescale 1ns/100ps
module tb;
	localparam int LIM = 20000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_v, ctrl_m;
	logic awready, wready, bvalid, arready, rvalid, sck;
	logic [1:0] bresp, rresp, resp;
	int hi_len, lo_len, n_edges, e, fail_count = 0, n_compared = 0;
	int exp_q[$];
	always #25 aclk = ~aclk;
	scg_top i_scg_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck(sck));
	scg_sck_target i_scg_sck_target (.aclk(aclk), .sck(sck),
		.hi_len(hi_len), .lo_len(lo_len), .n_edges(n_edges));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= LIM) begin
			fail_count++;
			$display("MISMATCH t=%0t wait ran out", $time);
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < LIM) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		tmo(n);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < LIM) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		tmo(n);
		resp = rresp;
		rd_v = rdata;
		rready <= 1'b0;
	endtask
	// Four edges later both measured phases were loaded from the new fields.
	task automatic run(input int s, input int h, input int l);
		int n;
		n = 0;
		ctrl_m = 32'((s << 16) | (h << 8) | l);
		// A zero field stands for one scaled period of two-to-s cycles.
		exp_q.push_back((h == 0 ? 1 : h) << s);
		exp_q.push_back((l == 0 ? 1 : l) << s);
		wr(scg_pkg::SCG_ADDR_CLK_CTRL, ctrl_m);
		rd(scg_pkg::SCG_ADDR_CLK_CTRL);
		chk(rd_v, ctrl_m);
		e = n_edges;
		while (n_edges < e + 4 && n < LIM) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
		chk(32'(hi_len), 32'(exp_q.pop_front()));
		chk(32'(lo_len), 32'(exp_q.pop_front()));
	endtask
	initial begin
		void'($urandom(46168));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(scg_pkg::SCG_ADDR_CLK_CTRL);
		chk(rd_v, 32'h0);
		// random value within the legal fields
		// Scale bit 19 is cleared so the scale stays below eight, and both
		// phase fields are odd values up to fifteen, so the low field is
		// never zero while the scale is not.
		ctrl_m = ($urandom & 32'hFFF70F0F) | 32'h00000101;
		wr(scg_pkg::SCG_ADDR_CLK_CTRL, ctrl_m);
		rd(scg_pkg::SCG_ADDR_CLK_CTRL);
		chk(rd_v, ctrl_m & 32'h000FFFFF);
		wr(8'h40, 32'h1);
		chk({30'h0, resp}, 32'h2);
		rd(8'h40);
		chk(rd_v, 32'h0);
		chk({30'h0, resp}, 32'h2);
		$display("register test done");
		wr(scg_pkg::SCG_ADDR_CLK_CTRL, 32'h00000101);
		wr(scg_pkg::SCG_ADDR_ENABLE, 32'h1);
		// software keeps scale, low field, lengths legal
		for (int i = 0; i < 6; i++)
			run($urandom % 4, $urandom % 15 + 1, $urandom % 15 + 1);
		run(8, 1, 1);
		run(3, 15, 1);
		run(2, 0, 3);
		run(0, 0, 0);
		run(0, 1, 1);
		$display("clock test done");
		wr(scg_pkg::SCG_ADDR_ENABLE, 32'h0);
		for (int i = 0; i < 50 && rd_v !== 32'h1; i++)
			rd(scg_pkg::SCG_ADDR_STATUS);
		chk(rd_v, 32'h1);
		e = n_edges;
		repeat (20) @(posedge aclk);
		chk(32'(n_edges), 32'(e));
		chk({31'h0, sck}, 32'h0);
		$display("stop test done");
		end_of_test();
	end
endmodule
